// ### rtl/fifo_core.sv
// Dual-port 64-by-36 FIFO core with flags, offsets and port drivers
//
// Summary of operation
// R1 - Reset held over four edges of each port
// R2 - Reset accepted at any moment
// R3 - Reset clears pointers, sets flag levels
// R4 - Full flag rises second edge after release
// R5 - Reset required before first write
// R6 - Offset loaded from flag selects at release
// R7 - Port A bus driven when selected and reading
// R8 - Port A write qualified by selects and full
// R9 - Port B bus driven when selected and reading
// R10 - Port B read qualified by selects and empty
// R11 - Selects ignored while strobe is low; bus drive (R7, R9) follows the selects regardless of strobe
// R12 - Flags pass two stages on own port
// R13 - Reads ignored while empty flag low
// R14 - Empty falls after last part is read
// R15 - Read pointer advances per fetched word
// R16 - Pointer compare; words readable after three cycles
// R17 - Empty stays low until second sync edge
// R18 - Late edges count as next sync cycle
// R19 - Writes ignored while full flag low
// R20 - Almost-empty low at offset or fewer words
// R21 - Almost-full low at depth minus offset
// R22 - Sixty-four 36-bit words in FIFO order
// R23 - Almost flags share pointer compare and sync
`timescale 1ns/1ps
`default_nettype none
module fifo_core #(
	parameter int WORD_W = fifo_core_pkg::WORD_W
) (
	input  wire logic              clk_i,
	input  wire logic              sys_rst_i,
	input  wire logic              flag_select_low_i,
	input  wire logic              flag_select_high_i,
	input  wire logic              port_a_select_n_i,
	input  wire logic              port_a_direction_i,
	input  wire logic              port_a_strobe_i,
	input  wire logic              port_a_mailbox_select_i,
	input  wire logic [WORD_W-1:0] port_a_bus_i,
	output logic      [WORD_W-1:0] port_a_bus_o,
	output logic                   port_a_bus_oe_o,
	input  wire logic              port_b_select_n_i,
	input  wire logic              port_b_direction_i,
	input  wire logic              port_b_strobe_i,
	input  wire logic              port_b_size_low_i,
	input  wire logic              port_b_size_high_i,
	input  wire logic [WORD_W-1:0] port_b_bus_i,
	output logic      [WORD_W-1:0] port_b_bus_o,
	output logic                   port_b_bus_oe_o,
	output logic                   full_flag_n_o,
	output logic                   almost_full_flag_n_o,
	output logic                   empty_flag_n_o,
	output logic                   almost_empty_flag_n_o,
	output logic                   mailbox_one_flag_n_o,
	output logic                   mailbox_two_flag_n_o
);

	localparam int PW = fifo_core_pkg::PTR_W;
	localparam int AW = fifo_core_pkg::ADDR_W;
	localparam int BD = fifo_core_pkg::BUF_DEPTH;
	localparam int CW = $clog2(BD+1);
	localparam int HW = fifo_core_pkg::HALF_W;
	localparam int YW = fifo_core_pkg::BYTE_W;

	// ==========================================================
	// Control pin bundles
	fifo_core_pkg::port_ctl_t ctl_a;
	fifo_core_pkg::port_ctl_t ctl_b;

	always_comb begin
		ctl_a.select_n  = port_a_select_n_i;
		ctl_a.direction = port_a_direction_i;
		ctl_a.strobe    = port_a_strobe_i;
		ctl_a.mode      = {1'b0, port_a_mailbox_select_i};
		ctl_b.select_n  = port_b_select_n_i;
		ctl_b.direction = port_b_direction_i;
		ctl_b.strobe    = port_b_strobe_i;
		ctl_b.mode      = {port_b_size_high_i, port_b_size_low_i};
	end

	// ==========================================================
	// Offset register, loaded once at reset release
	logic          rst_q;
	logic [PW-1:0] offset;
	logic [PW-1:0] next_offset;

	// Release is seen as reset low now and high one edge earlier
	always_comb begin
		next_offset = offset;
		if (sys_rst_i) begin
			next_offset = fifo_core_pkg::OFFSET_SEL_00;
		end else if (rst_q) begin
			case ({flag_select_high_i, flag_select_low_i}) // R6
				2'h3:    next_offset = fifo_core_pkg::OFFSET_SEL_11;
				2'h2:    next_offset = fifo_core_pkg::OFFSET_SEL_10;
				2'h1:    next_offset = fifo_core_pkg::OFFSET_SEL_01;
				default: next_offset = fifo_core_pkg::OFFSET_SEL_00;
			endcase
		end
	end

	// Reset value is the smallest offset until the release edge
	always_ff @(posedge clk_i) begin
		rst_q  <= sys_rst_i;
		offset <= next_offset;
	end

	// ==========================================================
	// Write side: pointer, full and almost-full flags
	logic [PW-1:0] wptr;
	logic [PW-1:0] next_wptr;
	logic [PW-1:0] rptr_sync;
	logic [PW-1:0] fill_a;
	logic [1:0]    startup;
	logic [1:0]    next_startup;
	logic          next_full_n;
	logic          next_afull_n;
	logic          next_a_oe;
	logic          wr_take;

	always_comb begin
		// Strobe gates the selects for the write take only; port A bus drive follows them directly
		wr_take = !ctl_a.select_n && ctl_a.direction && ctl_a.strobe // R11
			&& (ctl_a.mode == 2'h0) && full_flag_n_o; // R8 R19
		next_wptr = wptr + PW'(wr_take); // R22
		// Read pointer seen here is two edges old, so full is safe
		fill_a = next_wptr - rptr_sync; // R12
		next_startup = startup;
		if (startup != fifo_core_pkg::RELEASE_EDGES) begin
			next_startup = startup + 2'h1;
		end
		next_full_n = (next_startup == fifo_core_pkg::RELEASE_EDGES) // R4
			&& (fill_a != fifo_core_pkg::DEPTH_CNT);
		next_afull_n = fill_a < (fifo_core_pkg::DEPTH_CNT - offset); // R21 R23
		next_a_oe = !ctl_a.select_n && !ctl_a.direction; // R7
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin // R2 R3
			wptr                 <= '0;
			startup              <= 2'h0;
			full_flag_n_o        <= fifo_core_pkg::FULL_N_RST;
			almost_full_flag_n_o <= fifo_core_pkg::AFULL_N_RST;
			port_a_bus_oe_o      <= 1'b0;
			mailbox_one_flag_n_o <= fifo_core_pkg::MAILBOX_N_RST;
			mailbox_two_flag_n_o <= fifo_core_pkg::MAILBOX_N_RST;
		end else begin
			wptr                 <= next_wptr;
			startup              <= next_startup;
			full_flag_n_o        <= next_full_n;
			almost_full_flag_n_o <= next_afull_n;
			port_a_bus_oe_o      <= next_a_oe;
			mailbox_one_flag_n_o <= mailbox_one_flag_n_o;
			mailbox_two_flag_n_o <= mailbox_two_flag_n_o;
		end
	end

	// Mailbox data is not held in this core; port A reads show zero
	always_ff @(posedge clk_i) begin
		port_a_bus_o <= '0;
	end

	// ==========================================================
	// FIFO storage
	logic [WORD_W-1:0] mem [fifo_core_pkg::DEPTH];

	always_ff @(posedge clk_i) begin
		if (wr_take) begin
			mem[wptr[AW-1:0]] <= port_a_bus_i; // R22
		end
	end

	// ==========================================================
	// Pointer crossings, two stages each way
	logic [PW-1:0] rptr;
	logic [PW-1:0] wptr_sync;
	logic [PW-1:0] cptr;

	// Next write count feeds the first stage, so the empty flag register
	// is the second stage and the flag rises two edges after a write
	pointer_sync #(
		.WIDTH(PW)
	) u_wptr_sync (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.ptr_i    (next_wptr), // R17
		.ptr_o    (wptr_sync)
	);

	pointer_sync #(
		.WIDTH(PW)
	) u_rptr_sync (
		.clk_i    (clk_i),
		.sys_rst_i(sys_rst_i),
		.ptr_i    (cptr),
		.ptr_o    (rptr_sync)
	);

	// ==========================================================
	// Prefetch buffer between memory and the output register
	logic              fetch_valid;
	logic              fetch_ready;
	logic              buf_valid;
	logic [WORD_W-1:0] buf_data;
	logic [CW-1:0]     buf_count;
	logic              pop;

	// Memory stalls when the reader stops and the buffer fills
	two_entry_buffer #(
		.WIDTH(WORD_W),
		.DEPTH(BD)
	) u_out_buffer (
		.clk_i      (clk_i),
		.sys_rst_i  (sys_rst_i),
		.in_valid_i (fetch_valid),
		.in_ready_o (fetch_ready),
		.in_data_i  (mem[rptr[AW-1:0]]),
		.out_valid_o(buf_valid),
		.out_ready_i(pop),
		.out_data_o (buf_data),
		.count_o    (buf_count)
	);

	// ==========================================================
	// Read side: pointer, part counter, output register, flags
	logic [WORD_W-1:0] shift;
	logic [WORD_W-1:0] next_shift;
	logic [WORD_W-1:0] next_b_bus;
	logic [1:0]        part_size;
	logic [1:0]        next_part_size;
	logic [2:0]        parts_left;
	logic [2:0]        next_parts_left;
	logic [2:0]        parts_total;
	logic [PW-1:0]     next_rptr;
	logic [PW-1:0]     next_cptr;
	logic [PW-1:0]     fill_b;
	logic [CW-1:0]     next_buf_count;
	logic              rd_take;
	logic              fetch;
	logic              next_empty_n;
	logic              next_aempty_n;
	logic              next_b_oe;

	always_comb begin
		// Write count is one edge late here; flag register adds the second
		fetch_valid = (wptr_sync != rptr); // R12 R16 R17 R18
		fetch       = fetch_valid && fetch_ready;
		next_rptr   = rptr + PW'(fetch);
		rd_take = !ctl_b.select_n && !ctl_b.direction && ctl_b.strobe // R11
			&& (ctl_b.mode != fifo_core_pkg::SIZE_MAIL)
			&& empty_flag_n_o; // R10 R13
		pop = rd_take && (parts_left == 3'h0) && buf_valid;
		// Slots free only when a word leaves for the output register
		next_cptr = cptr + PW'(pop); // R15 R22
		case (ctl_b.mode)
			fifo_core_pkg::SIZE_WORD: parts_total = fifo_core_pkg::PARTS_WORD;
			fifo_core_pkg::SIZE_BYTE: parts_total = fifo_core_pkg::PARTS_BYTE;
			default:                  parts_total = fifo_core_pkg::PARTS_LONG;
		endcase
		next_shift      = shift;
		next_part_size  = part_size;
		next_parts_left = parts_left;
		if (pop) begin
			next_shift      = buf_data;
			next_part_size  = ctl_b.mode;
			next_parts_left = parts_total - 3'h1;
		end else if (rd_take && parts_left != 3'h0) begin
			// Later parts of a held word; low part goes out first
			if (part_size == fifo_core_pkg::SIZE_WORD) begin
				next_shift = shift >> HW;
			end else begin
				next_shift = shift >> YW;
			end
			next_parts_left = parts_left - 3'h1;
		end
		case (next_part_size)
			fifo_core_pkg::SIZE_WORD:
				next_b_bus = {{(WORD_W-HW){1'b0}}, next_shift[HW-1:0]};
			fifo_core_pkg::SIZE_BYTE:
				next_b_bus = {{(WORD_W-YW){1'b0}}, next_shift[YW-1:0]};
			default:
				next_b_bus = next_shift;
		endcase
		next_buf_count = buf_count + CW'(fetch) - CW'(pop);
		// Flag stays high while parts of the last word remain
		next_empty_n = (next_buf_count != '0) || (next_parts_left != 3'h0); // R14
		fill_b = (wptr_sync - next_rptr) + PW'(next_buf_count); // R16
		next_aempty_n = fill_b > offset; // R20 R23
		next_b_oe = !ctl_b.select_n && !ctl_b.direction; // R9
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin // R3
			rptr                  <= '0;
			cptr                  <= '0;
			shift                 <= '0;
			part_size             <= fifo_core_pkg::SIZE_LONG;
			parts_left            <= 3'h0;
			port_b_bus_o          <= '0;
			port_b_bus_oe_o       <= 1'b0;
			empty_flag_n_o        <= fifo_core_pkg::EMPTY_N_RST;
			almost_empty_flag_n_o <= fifo_core_pkg::AEMPTY_N_RST;
		end else begin
			rptr                  <= next_rptr;
			cptr                  <= next_cptr;
			shift                 <= next_shift;
			part_size             <= next_part_size;
			parts_left            <= next_parts_left;
			port_b_bus_o          <= next_b_bus;
			port_b_bus_oe_o       <= next_b_oe;
			empty_flag_n_o        <= next_empty_n;
			almost_empty_flag_n_o <= next_aempty_n;
		end
	end

endmodule
`default_nettype wire

// ### rtl/fifo_core_pkg.sv
// Shared constants and carrier types for the 64-by-36 FIFO core
package fifo_core_pkg;

	// ==========================================================
	// Storage geometry
	localparam int WORD_W = 36;
	localparam int DEPTH  = 64;
	localparam int ADDR_W = 6;
	localparam int PTR_W  = 7;
	localparam int BUF_DEPTH = 2;
	localparam logic [PTR_W-1:0] DEPTH_CNT = 7'h40;

	// ==========================================================
	// Almost-full / almost-empty offsets chosen at reset release
	localparam logic [PTR_W-1:0] OFFSET_SEL_11 = 7'h10;
	localparam logic [PTR_W-1:0] OFFSET_SEL_10 = 7'h0C;
	localparam logic [PTR_W-1:0] OFFSET_SEL_01 = 7'h08;
	localparam logic [PTR_W-1:0] OFFSET_SEL_00 = 7'h04;

	// ==========================================================
	// Reset behaviour
	localparam logic [1:0] RELEASE_EDGES = 2'h2;
	localparam logic       FULL_N_RST    = 1'b0;
	localparam logic       EMPTY_N_RST   = 1'b0;
	localparam logic       AEMPTY_N_RST  = 1'b0;
	localparam logic       AFULL_N_RST   = 1'b1;
	localparam logic       MAILBOX_N_RST = 1'b1;

	// ==========================================================
	// Port B size codes {size_high, size_low}
	localparam logic [1:0] SIZE_LONG = 2'h0;
	localparam logic [1:0] SIZE_WORD = 2'h1;
	localparam logic [1:0] SIZE_BYTE = 2'h2;
	localparam logic [1:0] SIZE_MAIL = 2'h3;
	localparam logic [2:0] PARTS_LONG = 3'h1;
	localparam logic [2:0] PARTS_WORD = 3'h2;
	localparam logic [2:0] PARTS_BYTE = 3'h4;
	localparam int HALF_W = 18;
	localparam int BYTE_W = 9;

	// ==========================================================
	// Control pins of one port, sampled together at the edge
	typedef struct packed {
		logic       select_n;
		logic       direction;
		logic       strobe;
		logic [1:0] mode;
	} port_ctl_t;

endpackage

// ### rtl/pointer_sync.sv
// Two-stage synchroniser for a pointer crossing between the two ports
`timescale 1ns/1ps
`default_nettype none
module pointer_sync #(
	parameter int WIDTH = 7
) (
	input  wire logic             clk_i,
	input  wire logic             sys_rst_i,
	input  wire logic [WIDTH-1:0] ptr_i,
	output var  logic [WIDTH-1:0] ptr_o
);

	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] next_stage_one;
	logic [WIDTH-1:0] next_ptr;

	// ==========================================================
	// First stage feeds only the second stage
	always_comb begin
		next_stage_one = ptr_i;
		next_ptr       = stage_one;
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			stage_one <= '0;
			ptr_o     <= '0;
		end else begin
			stage_one <= next_stage_one;
			ptr_o     <= next_ptr;
		end
	end

endmodule
`default_nettype wire

// ### rtl/two_entry_buffer.sv
// Small valid/ready buffer between FIFO memory and the read port
`timescale 1ns/1ps
`default_nettype none
module two_entry_buffer #(
	parameter int WIDTH = 36,
	parameter int DEPTH = 2
) (
	input  wire logic                       clk_i,
	input  wire logic                       sys_rst_i,
	input  wire logic                       in_valid_i,
	output var  logic                       in_ready_o,
	input  wire logic [WIDTH-1:0]           in_data_i,
	output var  logic                       out_valid_o,
	input  wire logic                       out_ready_i,
	output var  logic [WIDTH-1:0]           out_data_o,
	output var  logic [$clog2(DEPTH+1)-1:0] count_o
);

	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int CW = $clog2(DEPTH+1);

	logic [WIDTH-1:0] store [DEPTH];
	logic [IW-1:0]    wr_idx;
	logic [IW-1:0]    rd_idx;
	logic [IW-1:0]    next_wr_idx;
	logic [IW-1:0]    next_rd_idx;
	logic [CW-1:0]    next_count;
	logic             push;
	logic             pop;

	// ==========================================================
	// Handshake and index bookkeeping
	always_comb begin
		in_ready_o  = (count_o != CW'(DEPTH));
		out_valid_o = (count_o != '0);
		out_data_o  = store[rd_idx];
		push        = in_valid_i && in_ready_o;
		pop         = out_ready_i && out_valid_o;
		next_wr_idx = wr_idx;
		next_rd_idx = rd_idx;
		if (push) begin
			next_wr_idx = (wr_idx == IW'(DEPTH-1)) ? '0 : wr_idx + 1'b1;
		end
		if (pop) begin
			next_rd_idx = (rd_idx == IW'(DEPTH-1)) ? '0 : rd_idx + 1'b1;
		end
		next_count = count_o + CW'(push) - CW'(pop);
	end

	always_ff @(posedge clk_i) begin
		if (sys_rst_i) begin
			wr_idx  <= '0;
			rd_idx  <= '0;
			count_o <= '0;
		end else begin
			wr_idx  <= next_wr_idx;
			rd_idx  <= next_rd_idx;
			count_o <= next_count;
		end
	end

	// Storage holds no control state, so it needs no reset
	always_ff @(posedge clk_i) begin
		if (push) begin
			store[wr_idx] <= in_data_i;
		end
	end

endmodule
`default_nettype wire

// ### tb/fifo_core_properties.sv
// Port-level timing checker for the FIFO core
`timescale 1ns/1ps
`default_nettype none
module fifo_core_properties #(
	parameter int WORD_W = 36
) (
	input wire logic              clk_i,
	input wire logic              sys_rst_i,
	input wire logic              port_a_select_n_i,
	input wire logic              port_a_direction_i,
	input wire logic              port_a_strobe_i,
	input wire logic              port_a_mailbox_select_i,
	input wire logic              port_a_bus_oe_o,
	input wire logic              port_b_select_n_i,
	input wire logic              port_b_direction_i,
	input wire logic              port_b_strobe_i,
	input wire logic              port_b_size_low_i,
	input wire logic              port_b_size_high_i,
	input wire logic [WORD_W-1:0] port_b_bus_o,
	input wire logic              port_b_bus_oe_o,
	input wire logic              full_flag_n_o,
	input wire logic              almost_full_flag_n_o,
	input wire logic              empty_flag_n_o,
	input wire logic              almost_empty_flag_n_o,
	input wire logic              mailbox_one_flag_n_o,
	input wire logic              mailbox_two_flag_n_o
);
	// ==========================================================
	// Helpers: taken writes, read attempts, cycles since a write
	logic       wr_take;
	logic       rd_try;
	logic [1:0] gap;
	logic [1:0] next_gap;
	default clocking cb @(posedge clk_i); endclocking
	assign wr_take = !port_a_select_n_i && port_a_direction_i
		&& port_a_strobe_i && !port_a_mailbox_select_i && full_flag_n_o;
	assign rd_try = !port_b_select_n_i && !port_b_direction_i
		&& port_b_strobe_i;
	// Saturates so a quiet FIFO is told apart from a pending write
	always_comb next_gap = wr_take ? 2'h0 : gap + {1'b0, gap != 2'h3};
	always_ff @(posedge clk_i) gap <= sys_rst_i ? 2'h3 : next_gap;

	// ==========================================================
	// Assertions
	a_rst_flag_levels: assert property (sys_rst_i |=> !full_flag_n_o
		&& !empty_flag_n_o && !almost_empty_flag_n_o
		&& almost_full_flag_n_o && mailbox_one_flag_n_o
		&& mailbox_two_flag_n_o) else $error("reset flag levels wrong");
	a_full_after_release: assert property ($fell(sys_rst_i) |->
		!full_flag_n_o ##[1:3] full_flag_n_o)
		else $error("full flag late after reset");
	a_drive_port_a: assert property (disable iff (sys_rst_i) 1'b1 |=>
		port_a_bus_oe_o == $past(!port_a_select_n_i && !port_a_direction_i))
		else $error("port A bus drive wrong");
	a_drive_port_b: assert property (disable iff (sys_rst_i) 1'b1 |=>
		port_b_bus_oe_o == $past(!port_b_select_n_i && !port_b_direction_i))
		else $error("port B bus drive wrong");
	a_strobe_low_hold: assert property (disable iff (sys_rst_i)
		!port_b_strobe_i |=> $stable(port_b_bus_o))
		else $error("output moved without strobe");
	a_mail_size_hold: assert property (disable iff (sys_rst_i)
		rd_try && port_b_size_low_i && port_b_size_high_i
		|=> $stable(port_b_bus_o)) else $error("read with mail size");
	a_empty_read_ignored: assert property (disable iff (sys_rst_i)
		rd_try && !empty_flag_n_o |=> $stable(port_b_bus_o))
		else $error("read taken while empty");
	a_empty_sync_delay: assert property (disable iff (sys_rst_i)
		wr_take && !empty_flag_n_o && gap == 2'h3 |=>
		!empty_flag_n_o [*2] ##1 empty_flag_n_o)
		else $error("empty flag sync delay wrong");
	a_empty_rise_cause: assert property (disable iff (sys_rst_i)
		$rose(empty_flag_n_o) |-> $past(wr_take, 3))
		else $error("empty rose without write");
	a_full_fall_cause: assert property (disable iff (sys_rst_i)
		$fell(full_flag_n_o) |-> $past(wr_take))
		else $error("full fell without write");
	c_full: cover property ($fell(full_flag_n_o));
	c_empty: cover property ($rose(empty_flag_n_o));
	c_byte: cover property (rd_try && empty_flag_n_o && port_b_size_high_i);
endmodule
bind fifo_core fifo_core_properties #(.WORD_W(WORD_W)) u_props (.*);
`default_nettype wire

// ### tb/fifo_core_tb.sv
// Self-checking bench for the FIFO core with a port B reader model
`timescale 1ns/1ps
`default_nettype none
module fifo_core_tb;
	// ==========================================================
	// Pins, named as the design ports
	logic clk_i, sys_rst_i, flag_select_low_i, flag_select_high_i;
	logic port_a_select_n_i, port_a_direction_i, port_a_strobe_i;
	logic port_a_mailbox_select_i, port_a_bus_oe_o, port_b_bus_oe_o;
	logic port_b_select_n_i, port_b_direction_i, port_b_strobe_i;
	logic port_b_size_low_i, port_b_size_high_i, full_flag_n_o;
	logic almost_full_flag_n_o, empty_flag_n_o, almost_empty_flag_n_o;
	logic mailbox_one_flag_n_o, mailbox_two_flag_n_o;
	logic [35:0] port_a_bus_i, port_a_bus_o, port_b_bus_i, port_b_bus_o;
	logic rd_en, rd_slow, rd_try;
	logic [1:0] rd_size, try_size, b_size, lat_size;
	logic [35:0] q[$];
	logic [31:0] seed;
	int num_errors, check_count, cycles, part, k, x, xo;

	assign port_b_size_low_i = b_size[0];
	assign port_b_size_high_i = b_size[1];
	fifo_core u_dut (.*);
	port_b_reader u_reader (.clk_i(clk_i), .en_i(rd_en), .slow_i(rd_slow),
		.size_i(rd_size), .empty_flag_n_i(empty_flag_n_o),
		.select_n_o(port_b_select_n_i), .direction_o(port_b_direction_i),
		.strobe_o(port_b_strobe_i), .size_o(b_size), .data_o(port_b_bus_i),
		.try_o(rd_try), .try_size_o(try_size));

	initial begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// ==========================================================
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic chk_bit(input logic got, input logic exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: flag %b not %b", $time, got, exp);
		end
	endtask
	task automatic chk_word(input logic [35:0] got, input logic [35:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: data %h not %h", $time, got, exp);
		end
	endtask
	task automatic test_done;
		$display("errors %0d checks %0d", num_errors, check_count);
		if (num_errors == 0 && check_count > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	// One port A cycle: a write, or random selects with strobe low
	task automatic cyc(input logic go, input logic mb);
		@(negedge clk_i);
		seed = xs(seed);
		port_a_select_n_i = go ? 1'b0 : seed[0];
		port_a_direction_i = go ? 1'b1 : seed[1];
		port_a_strobe_i = go;
		port_a_mailbox_select_i = mb;
		port_a_bus_i = {seed[7:4], seed};
		if (go && !mb && full_flag_n_o === 1'b1) q.push_back(port_a_bus_i);
	endtask
	// Long reset, flag levels checked before release
	task automatic do_reset(input logic [1:0] fs);
		@(negedge clk_i);
		sys_rst_i = 1'b1;
		{flag_select_high_i, flag_select_low_i} = fs;
		repeat (20) @(negedge clk_i);
		chk_word({30'h0, full_flag_n_o, empty_flag_n_o, almost_empty_flag_n_o,
			almost_full_flag_n_o, mailbox_one_flag_n_o,
			mailbox_two_flag_n_o}, 36'h7);
		sys_rst_i = 1'b0;
		q.delete();
		part = 0;
		cyc(1'b0, 1'b0);
		chk_bit(full_flag_n_o, 1'b0);
		repeat (2) cyc(1'b0, 1'b0);
		chk_bit(full_flag_n_o, 1'b1);
	endtask
	// Reader empties the queue, keeps trying, then empty must be low
	task automatic drain(input logic [1:0] sz, input logic slow);
		rd_size <= sz;
		rd_slow <= slow;
		rd_en <= 1'b1;
		for (k = 0; k < 600 && q.size() > 0; k++) cyc(1'b0, 1'b0);
		repeat (4) cyc(1'b0, 1'b0);
		rd_en <= 1'b0;
		chk_bit(q.size() == 0, 1'b1);
		chk_bit(empty_flag_n_o, 1'b0);
	endtask

	// ==========================================================
	// Reference model: each honoured read yields the next part
	always @(negedge clk_i) begin
		if (rd_try === 1'b1 && try_size != 2'h3) begin
			if (part == 0) lat_size = try_size;
			x = lat_size == 2'h0 ? 36 : (lat_size == 2'h1 ? 18 : 9);
			chk_word(port_b_bus_o, (q[0] >> (part * x))
				& ((36'h1 << x) - 36'h1));
			part++;
			if (part * x == 36) begin
				void'(q.pop_front());
				part = 0;
			end
		end
	end
	// Hang guard, far above the expected run length
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			test_done;
		end
	end

	// ==========================================================
	// Main sequence
	initial begin
		sys_rst_i = 1'b1;
		{flag_select_high_i, flag_select_low_i} = 2'h0;
		{port_a_select_n_i, port_a_direction_i} = 2'h3;
		{port_a_strobe_i, port_a_mailbox_select_i} = 2'h0;
		port_a_bus_i = 36'h0;
		{rd_en, rd_slow, rd_size} = 4'h0;
		seed = 32'hDE30;
		// Every offset code: almost flags, fill to full, drain
		for (int c = 0; c < 4; c++) begin
			do_reset(c[1:0]);
			xo = 4 * (c + 1);
			repeat (xo) cyc(1'b1, 1'b0);
			repeat (8) cyc(1'b0, 1'b0);
			chk_bit(almost_empty_flag_n_o, 1'b0);
			chk_bit(almost_full_flag_n_o, 1'b1);
			chk_word(port_a_bus_o, 36'h0);
			cyc(1'b1, 1'b0);
			cyc(1'b1, 1'b1);
			repeat (8) cyc(1'b0, 1'b0);
			chk_bit(almost_empty_flag_n_o, 1'b1);
			for (k = 0; k < 80 && full_flag_n_o === 1'b1; k++) cyc(1'b1, 1'b0);
			repeat (3) cyc(1'b1, 1'b0);
			repeat (8) cyc(1'b0, 1'b0);
			chk_bit(full_flag_n_o, 1'b0);
			chk_bit(almost_full_flag_n_o, 1'b0);
			chk_bit(q.size() == 64, 1'b1);
			drain(2'h0, c[0]);
		end
		// Mail size reads are refused, then byte and half-word reads
		repeat (3) cyc(1'b1, 1'b0);
		rd_size <= 2'h3;
		rd_en <= 1'b1;
		repeat (8) cyc(1'b0, 1'b0);
		drain(2'h2, 1'b1);
		repeat (2) cyc(1'b1, 1'b0);
		drain(2'h1, 1'b0);
		test_done;
	end
endmodule
`default_nettype wire

// ### tb/port_b_reader.sv
// Port B bus master model that reads the FIFO, promptly or with stalls
`timescale 1ns/1ps
`default_nettype none
module port_b_reader (
	input  wire logic        clk_i,
	input  wire logic        en_i,
	input  wire logic        slow_i,
	input  wire logic [1:0]  size_i,
	input  wire logic        empty_flag_n_i,
	output logic             select_n_o,
	output logic             direction_o,
	output logic             strobe_o,
	output logic [1:0]       size_o,
	output logic [35:0]      data_o,
	output logic             try_o,
	output logic [1:0]       try_size_o
);
	logic [3:0] tick;
	// Idle at time zero
	initial begin
		tick = 4'h0;
		select_n_o = 1'b1;
		direction_o = 1'b1;
		strobe_o = 1'b0;
		size_o = 2'h0;
		data_o = 36'h0;
		try_o = 1'b0;
		try_size_o = 2'h0;
	end
	// Pins change on the falling edge; a slow reader strobes 1 in 4
	always @(negedge clk_i) begin
		tick <= tick + 4'h1;
		select_n_o <= !en_i;
		direction_o <= en_i ? 1'b0 : tick[1];
		strobe_o <= en_i && (!slow_i || tick[1:0] == 2'h0);
		size_o <= size_i;
		data_o <= ~data_o; // Unused line toggles so no stale level shows
	end
	// Report each attempt the device should honour at this edge
	always @(posedge clk_i) begin
		try_o <= !select_n_o && !direction_o && strobe_o && empty_flag_n_i;
		try_size_o <= size_o;
	end
endmodule
`default_nettype wire
